// [src/split_fetch_defines.svh]
// constants for the screen start address and split screen fetch block
// Behaviour
// - screen-one start pointer is 17 bits from three byte registers, top one bit 16
// - landscape: start pointer is a 16-bit word offset to the upper left pixel
// - portrait: start pointer is a byte offset, halving the panning step
// - landscape unit step moves 16, 8, 4 or 2 pixels at 1, 2, 4, 8 bpp
// - portrait unit step moves 8, 4, 2 or 1 pixels at 1, 2, 4, 8 bpp
// - each frame starts fetching screen one at its start pointer, top left
// - line to line step is display width plus extra virtual width words
// - in split screen the screen-one image is always on top
// - the screen-one vertical size gives the line where image two begins
// - the split may fall on any scan line from 1 up; a vertical size of zero never shows image two
// - eight-bit line offset adds extra words per line; zero means none
// - ten-bit vertical size; at or above line count image two never shows
// - portrait never uses the screen-two pointer, so no split screen
// - fetchable display memory is 81920 bytes
`ifndef SPLIT_FETCH_DEFINES_SVH
`define SPLIT_FETCH_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_S1_LOW     8'h0C
`define IDX_S1_MID     8'h0D
`define IDX_S2_LOW     8'h0E
`define IDX_S2_HIGH    8'h0F
`define IDX_S1_HIGH    8'h10
`define IDX_LINE_OFS   8'h11
`define IDX_VSIZE_LOW  8'h13
`define IDX_VSIZE_HIGH 8'h14
`define IDX_CTRL       8'h20
`define IDX_LINES      8'h21
`define IDX_STATUS     8'h22
`define IDX_FETCH      8'h23

// control register fields
`define CTRL_PORTRAIT_BIT 0
`define CTRL_BPP_LSB      1
`define CTRL_WIDTH_LSB    8

// status register fields
`define STAT_LINE_LSB     0
`define STAT_SCREEN2_BIT  16
`define STAT_RANGE_BIT    17
`define STAT_PAN_LSB      20

// reset values
`define LINES_RST     10'h0F0
`define WIDTH_RST     8'h00

// display memory size in bytes
`define MEM_BYTES     18'h14000

`endif

// [src/split_fetch_pkg.sv]
// types shared by the split screen fetch logic
package split_fetch_pkg;

  typedef enum logic [1:0] {
    BPP1,
    BPP2,
    BPP4,
    BPP8
  } bpp_t;

  typedef logic [16:0] byte_addr_t;

endpackage

// [src/start_to_byte.sv]
// start pointer to display memory byte address conversion
`timescale 1ns/100ps
module start_to_byte
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      portrait,
  input  wire logic [16:0]               start,
  output      split_fetch_pkg::byte_addr_t byte_addr_q
);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      byte_addr_q <= 17'h00000;
    else if (portrait)
      byte_addr_q <= start;
    else
      byte_addr_q <= {start[15:0], 1'b0};
  end

endmodule

// [src/line_stride.sv]
// virtual line stride in bytes
`timescale 1ns/100ps
module line_stride
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  width_words,
  input  wire logic [7:0]  extra_words,
  output      logic [10:0] stride_q
);

  logic [8:0] words;

  assign words = {1'b0, width_words} + {1'b0, extra_words};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stride_q <= 11'h000;
    else
      stride_q <= {1'b0, words, 1'b0};
  end

endmodule

// [src/split_fetch.sv]
// screen start address, virtual stride and split screen fetch addressing
`timescale 1ns/100ps
`include "split_fetch_defines.svh"
module split_fetch
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        frame_start,
  input  wire logic        line_start,
  output      logic        fetch_req,
  output      logic [16:0] fetch_addr,
  output      logic [9:0]  fetch_line,
  output      logic        fetch_screen2
);

  // software registers
  logic [7:0]  s1_low_q;
  logic [7:0]  s1_mid_q;
  logic        s1_high_q;
  logic [7:0]  s2_low_q;
  logic [7:0]  s2_high_q;
  logic [7:0]  line_ofs_q;
  logic [7:0]  vsize_low_q;
  logic [1:0]  vsize_high_q;
  logic        portrait_q;
  split_fetch_pkg::bpp_t bpp_q;
  logic [7:0]  width_q;
  logic [9:0]  lines_q;

  // apb decode
  logic [7:0]  idx;
  logic        setup;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_d;

  // converted start addresses, stride and frame sampled copies
  split_fetch_pkg::byte_addr_t s1_byte;
  split_fetch_pkg::byte_addr_t s2_byte;
  logic [10:0] stride;
  logic [16:0] s1_ptr;
  split_fetch_pkg::byte_addr_t f_s2_q;
  logic [10:0] f_stride_q;
  logic [9:0]  f_vsize_q;
  logic [9:0]  f_lines_q;
  logic        f_split_q;

  // line walker
  logic [17:0] cur_addr_q;
  logic [9:0]  line_q;
  logic        screen2_q;
  logic        range_err_q;
  logic [17:0] next_addr;
  logic        to_screen2;
  logic [4:0]  pan_pixels;
  logic [9:0]  vsize;
  logic        line_take;

  assign idx    = paddr[9:2];
  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite && pready;
  assign vsize  = {vsize_high_q, vsize_low_q};
  assign s1_ptr = {s1_high_q, s1_mid_q, s1_low_q};
  // a line_start after the frame's last line is refused
  assign line_take = line_start && !frame_start && (line_q < f_lines_q);

  // unmapped indices answer with an error
  always_comb
  begin
    mapped = 1'b1;
    case (idx)
      `IDX_S1_LOW, `IDX_S1_MID, `IDX_S1_HIGH, `IDX_S2_LOW, `IDX_S2_HIGH,
      `IDX_LINE_OFS, `IDX_VSIZE_LOW, `IDX_VSIZE_HIGH, `IDX_CTRL, `IDX_LINES,
      `IDX_STATUS, `IDX_FETCH:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  // pixels moved per unit change of the start pointer
  always_comb
  begin
    pan_pixels = 5'h00;
    case (bpp_q)
      split_fetch_pkg::BPP1: pan_pixels = 5'h10;
      split_fetch_pkg::BPP2: pan_pixels = 5'h08;
      split_fetch_pkg::BPP4: pan_pixels = 5'h04;
      split_fetch_pkg::BPP8: pan_pixels = 5'h02;
      default:               pan_pixels = 5'h00;
    endcase
    // a byte holds half the pixels of a word
    if (portrait_q)
      pan_pixels = pan_pixels >> 1;
  end

  always_comb
  begin
    rd_d = 32'h00000000;
    case (idx)
      `IDX_S1_LOW:     rd_d[7:0] = s1_low_q;
      `IDX_S1_MID:     rd_d[7:0] = s1_mid_q;
      `IDX_S1_HIGH:    rd_d[0] = s1_high_q;
      `IDX_S2_LOW:     rd_d[7:0] = s2_low_q;
      `IDX_S2_HIGH:    rd_d[7:0] = s2_high_q;
      `IDX_LINE_OFS:   rd_d[7:0] = line_ofs_q;
      `IDX_VSIZE_LOW:  rd_d[7:0] = vsize_low_q;
      `IDX_VSIZE_HIGH: rd_d[1:0] = vsize_high_q;
      `IDX_CTRL:
      begin
        rd_d[`CTRL_PORTRAIT_BIT] = portrait_q;
        rd_d[`CTRL_BPP_LSB +: 2] = bpp_q;
        rd_d[`CTRL_WIDTH_LSB +: 8] = width_q;
      end
      `IDX_LINES:      rd_d[9:0] = lines_q;
      // status and fetch words are read only
      `IDX_STATUS:
      begin
        rd_d[`STAT_LINE_LSB +: 10] = line_q;
        rd_d[`STAT_SCREEN2_BIT] = screen2_q;
        rd_d[`STAT_RANGE_BIT] = range_err_q;
        rd_d[`STAT_PAN_LSB +: 5] = pan_pixels;
      end
      `IDX_FETCH:      rd_d[16:0] = cur_addr_q[16:0];
      default:         rd_d = 32'h00000000;
    endcase
  end

  // zero wait state: answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= setup && !mapped;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
      prdata <= rd_d;
  end

  // screen-one start pointer bytes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_low_q  <= 8'h00;
      s1_mid_q  <= 8'h00;
      s1_high_q <= 1'b0;
    end
    else if (wr_en)
    begin
      if (idx == `IDX_S1_LOW)
        s1_low_q <= pwdata[7:0];
      if (idx == `IDX_S1_MID)
        s1_mid_q <= pwdata[7:0];
      if (idx == `IDX_S1_HIGH)
        s1_high_q <= pwdata[0];
    end
  end

  // screen-two pointer, line offset and vertical size
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s2_low_q     <= 8'h00;
      s2_high_q    <= 8'h00;
      line_ofs_q   <= 8'h00;
      vsize_low_q  <= 8'h00;
      vsize_high_q <= 2'h0;
    end
    else if (wr_en)
    begin
      if (idx == `IDX_S2_LOW)
        s2_low_q <= pwdata[7:0];
      if (idx == `IDX_S2_HIGH)
        s2_high_q <= pwdata[7:0];
      if (idx == `IDX_LINE_OFS)
        line_ofs_q <= pwdata[7:0];
      if (idx == `IDX_VSIZE_LOW)
        vsize_low_q <= pwdata[7:0];
      if (idx == `IDX_VSIZE_HIGH)
        vsize_high_q <= pwdata[1:0];
    end
  end

  // orientation, colour depth, display width and line count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      portrait_q <= 1'b0;
      bpp_q      <= split_fetch_pkg::BPP1;
      width_q    <= `WIDTH_RST;
      lines_q    <= `LINES_RST;
    end
    else if (wr_en)
    begin
      if (idx == `IDX_CTRL)
      begin
        portrait_q <= pwdata[`CTRL_PORTRAIT_BIT];
        bpp_q      <= split_fetch_pkg::bpp_t'(pwdata[`CTRL_BPP_LSB +: 2]);
        width_q    <= pwdata[`CTRL_WIDTH_LSB +: 8];
      end
      if (idx == `IDX_LINES)
        lines_q <= pwdata[9:0];
    end
  end

  start_to_byte u_s1_byte
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .portrait  (portrait_q),
    .start     (s1_ptr),
    .byte_addr_q (s1_byte)
  );

  start_to_byte u_s2_byte
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .portrait  (1'b0),
    .start     ({1'b0, s2_high_q, s2_low_q}),
    .byte_addr_q (s2_byte)
  );

  line_stride u_stride
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .width_words (width_q),
    .extra_words (line_ofs_q),
    .stride_q    (stride)
  );

  // frame-start snapshot of everything that steers the walk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      f_s2_q     <= 17'h00000;
      f_stride_q <= 11'h000;
      f_vsize_q  <= 10'h000;
      f_lines_q  <= 10'h000;
      f_split_q  <= 1'b0;
    end
    else if (frame_start)
    begin
      f_s2_q     <= s2_byte;
      f_stride_q <= stride;
      f_vsize_q  <= vsize;
      f_lines_q  <= lines_q;
      f_split_q  <= !portrait_q && (vsize < lines_q);
    end
  end

  // the boundary is any line from 1 up that the vertical size names; zero never switches
  assign to_screen2 = f_split_q && !screen2_q
                      && ((line_q + 10'h001) == f_vsize_q);
  assign next_addr  = to_screen2 ? {1'b0, f_s2_q}
                                 : cur_addr_q + {7'h00, f_stride_q};

  // line walker: screen one on top, screen two below the split
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_addr_q <= 18'h00000;
      line_q     <= 10'h000;
      screen2_q  <= 1'b0;
    end
    else if (frame_start)
    begin
      cur_addr_q <= {1'b0, s1_byte};
      line_q     <= 10'h000;
      screen2_q  <= 1'b0;
    end
    else if (line_start && (line_q < f_lines_q))
    begin
      cur_addr_q <= next_addr;
      line_q     <= line_q + 10'h001;
      if (to_screen2)
        screen2_q <= 1'b1;
    end
  end

  // fetch request for each displayed line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fetch_req <= 1'b0;
    else
      fetch_req <= line_take;
  end

  // fetch payload holds until the next fetch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fetch_addr    <= 17'h00000;
      fetch_line    <= 10'h000;
      fetch_screen2 <= 1'b0;
    end
    else if (line_take)
    begin
      fetch_addr    <= cur_addr_q[16:0];
      fetch_line    <= line_q;
      fetch_screen2 <= screen2_q;
    end
  end

  // a line beyond display memory flags until the next frame; a frame start clears it, since a line_start in that cycle is refused
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      range_err_q <= 1'b0;
    else if (line_take && (cur_addr_q >= `MEM_BYTES))
      range_err_q <= 1'b1;
    else if (frame_start)
      range_err_q <= 1'b0;
  end

endmodule

// [test/split_fetch_properties.sv]
// port checker for the split screen fetch block
`timescale 1ns/100ps
module split_fetch_properties
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        frame_start,
  input wire logic        line_start,
  input wire logic        fetch_req,
  input wire logic [16:0] fetch_addr,
  input wire logic [9:0]  fetch_line,
  input wire logic        fetch_screen2
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing after setup");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err;
    pslverr |-> pready && (pwrite || prdata == 32'h0);
  endproperty
  a_err: assert property (p_err) else $error("bad error response");
  property p_cause;
    fetch_req |-> $past(line_start) && !$past(frame_start);
  endproperty
  a_cause: assert property (p_cause) else $error("fetch without line start");
  property p_first;
    frame_start ##1 line_start |=> fetch_req && fetch_line == 10'h000 && !fetch_screen2;
  endproperty
  a_first: assert property (p_first) else $error("bad first line");
  property p_hold;
    !fetch_req |-> $stable(fetch_addr) && $stable(fetch_line);
  endproperty
  a_hold: assert property (p_hold) else $error("fetch outputs moved");
  property p_step;
    fetch_req && $past(fetch_req) |-> fetch_line == $past(fetch_line) + 10'h001;
  endproperty
  a_step: assert property (p_step) else $error("line count skipped");
  property p_s2;
    fetch_req && !fetch_screen2 && $past(fetch_screen2) |-> fetch_line == 10'h000;
  endproperty
  a_s2: assert property (p_s2) else $error("screen two left inside a frame");
  c_err: cover property (pslverr);
  c_s2: cover property (fetch_req && fetch_screen2);
  c_b2b: cover property (fetch_req && $past(fetch_req));
endmodule

bind split_fetch split_fetch_properties i_split_fetch_properties (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .frame_start(frame_start), .line_start(line_start),
  .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_line(fetch_line),
  .fetch_screen2(fetch_screen2));

// [test/testbench.sv]
// self-checking bench for the split screen fetch block
`timescale 1ns/100ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, frame_start, line_start, er, por;
  logic        pready, pslverr, fetch_req, fetch_screen2;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [16:0] fetch_addr, ptr;
  logic [9:0]  fetch_line, vs, ln;
  logic [15:0] s2;
  logic [7:0]  w, off;
  logic [1:0]  bpp;
  int          n_errors, n_tests, nf;
  split_fetch i_split_fetch (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_start(frame_start), .line_start(line_start),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_line(fetch_line),
    .fetch_screen2(fetch_screen2));
  initial
  begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] d);
    int k;
    psel    <= 1'h1;
    penable <= 1'h0;
    paddr   <= {2'h0, idx, 2'h0};
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge pclk);
      if (pready === 1'h1)
        break;
    end
    if (k == 16)
    begin
      n_errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  function automatic logic split_at(input int n);
    return !por && vs < ln && n >= vs;
  endfunction
  function automatic int exp_addr(input int n);
    int s;
    s = 2 * (w + off);
    if (split_at(n))
      return {s2, 1'h0} + (n - vs) * s;
    return (por ? ptr : {ptr[15:0], 1'h0}) + n * s;
  endfunction
  function automatic logic exp_range();
    for (int n = 0; n < ln; n++)
      if (exp_addr(n) >= 32'h00014000)
        return 1'h1;
    return 1'h0;
  endfunction
  always @(posedge pclk)
    if (frame_start === 1'h1)
      nf = 0;
    else if (fetch_req === 1'h1)
    begin
      chk(fetch_addr, exp_addr(nf) & 32'h0001FFFF);
      chk(fetch_line, nf);
      chk(fetch_screen2, split_at(nf));
      nf++;
    end
  initial
  begin
    {psel, penable, pwrite, frame_start, line_start} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'h0;
    n_errors = 0;
    n_tests = 0;
    void'($urandom(57));
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(8'h21, 1'h0, 32'h0);
    chk(rd, 32'h000000F0);
    apb(8'h0C, 1'h0, 32'h0);
    chk(rd, 32'h0);
    apb(8'h12, 1'h1, 32'h000000FF);
    chk(er, 1'h1);
    apb(8'h12, 1'h0, 32'h0);
    chk(er, 1'h1);
    chk(rd, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      por = i[2];
      bpp = i[1:0];
      ptr = (i == 3) ? 17'h00000 : 17'($urandom);
      s2 = 16'($urandom);
      w = 8'($urandom);
      off = 8'($urandom);
      ln = 10'(3 + $urandom % 8);
      vs = (i == 0) ? ln : (i == 1) ? 10'(ln - 1) : 10'(1 + $urandom % ln);
      apb(8'h0C, 1'h1, {24'h0, ptr[7:0]});
      apb(8'h0D, 1'h1, {24'h0, ptr[15:8]});
      apb(8'h10, 1'h1, {24'h0, 7'($urandom), ptr[16]});
      apb(8'h0E, 1'h1, {24'h0, s2[7:0]});
      apb(8'h0F, 1'h1, {24'h0, s2[15:8]});
      apb(8'h11, 1'h1, {24'h0, off});
      apb(8'h13, 1'h1, {24'h0, vs[7:0]});
      apb(8'h14, 1'h1, {30'h0, vs[9:8]});
      apb(8'h20, 1'h1, {16'h0, w, 5'h00, bpp, por});
      apb(8'h21, 1'h1, {22'h0, ln});
      apb(8'h22, 1'h0, 32'h0);
      chk(rd[24:20], (por ? 8 : 16) >> bpp);
      frame_start <= 1'h1;
      @(posedge pclk);
      frame_start <= 1'h0;
      for (int n = 0; n <= ln; n++)
      begin
        line_start <= 1'h1;
        @(posedge pclk);
        if (n == 1)
        begin
          line_start <= 1'h0;
          apb(8'h0C, 1'h1, {24'h0, ~ptr[7:0]});
        end
        else if ($urandom % 2)
        begin
          line_start <= 1'h0;
          @(posedge pclk);
        end
      end
      line_start <= 1'h0;
      repeat (3) @(posedge pclk);
      chk(nf, ln);
      apb(8'h22, 1'h0, 32'h0);
      chk(rd[9:0], ln);
      chk(rd[16], split_at(ln - 1));
      chk(rd[17], exp_range());
      apb(8'h23, 1'h0, 32'h0);
      chk(rd, exp_addr(ln) & 32'h0001FFFF);
      $display("test %0d done", i);
    end
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk({fetch_req, fetch_addr}, 32'h00000000);
    apb(8'h0C, 1'h0, 32'h0);
    chk(rd, 32'h00000000);
    apb(8'h21, 1'h0, 32'h0);
    chk(rd, 32'h000000F0);
    apb(8'h22, 1'h0, 32'h0);
    chk(rd[17:0], 32'h00000000);
    $display("test second reset done");
    conclude();
  end
endmodule
